// ---- logic/bfmu_pkg.sv ----
package bfmu_pkg;

   // Status register bit positions.
   localparam int unsigned SR_C = 0;
   localparam int unsigned SR_Z = 1;
   localparam int unsigned SR_N = 2;
   localparam int unsigned SR_V = 3;
   localparam int unsigned SR_S = 4;
   localparam int unsigned SR_H = 5;
   localparam int unsigned SR_T = 6;
   localparam int unsigned SR_I = 7;

   // Values after reset.
   localparam logic [7:0] SR_RESET  = 8'h00;
   localparam logic [7:0] RES_RESET = 8'h00;

   // Cycle counts per operation class.
   localparam int unsigned IO_BIT_CYCLES = 2;
   localparam int unsigned ONE_CYCLE     = 1;

   // Operation codes presented by the decoder.
   localparam logic [4:0] OP_NOP                   = 5'h00;
   localparam logic [4:0] OP_IO_BIT_SET            = 5'h01;
   localparam logic [4:0] OP_IO_BIT_CLEAR          = 5'h02;
   localparam logic [4:0] OP_LOGICAL_LEFT_SHIFT    = 5'h03;
   localparam logic [4:0] OP_LOGICAL_RIGHT_SHIFT   = 5'h04;
   localparam logic [4:0] OP_ROTATE_LEFT_CARRY     = 5'h05;
   localparam logic [4:0] OP_ROTATE_RIGHT_CARRY    = 5'h06;
   localparam logic [4:0] OP_ARITH_SHIFT_RIGHT     = 5'h07;
   localparam logic [4:0] OP_NIBBLE_SWAP           = 5'h08;
   localparam logic [4:0] OP_STATUS_BIT_FORCE_ONE  = 5'h09;
   localparam logic [4:0] OP_STATUS_BIT_FORCE_ZERO = 5'h0A;
   localparam logic [4:0] OP_REG_BIT_TO_TRANSFER   = 5'h0B;
   localparam logic [4:0] OP_TRANSFER_TO_REG_BIT   = 5'h0C;
   localparam logic [4:0] OP_SLEEP                 = 5'h0D;
   localparam logic [4:0] OP_WATCHDOG_RESTART      = 5'h0E;

   typedef enum logic [1:0] {
      BFMU_IDLE,
      BFMU_IO_RMW
   } bfmu_state_t;

endpackage : bfmu_pkg

// ---- logic/bfmu_shifter.sv ----
`timescale 1ns/1ps

// Shift and rotate datapath with flag outcomes; purely combinational.
module bfmu_shifter (
   input  wire logic [4:0] op,
   input  wire logic [7:0] operand,
   input  wire logic       carry_in,
   output logic      [7:0] result,
   output logic            carry_out,
   output logic            zero,
   output logic            negative,
   output logic            overflow
);
   import bfmu_pkg::*;

   // Select the shifted value and the bit expelled into carry.
   always_comb begin
      result    = operand;
      carry_out = carry_in;
      case (op)
         OP_LOGICAL_LEFT_SHIFT: begin
            result    = {operand[6:0], 1'b0};
            carry_out = operand[7];
         end
         OP_LOGICAL_RIGHT_SHIFT: begin
            result    = {1'b0, operand[7:1]};
            carry_out = operand[0];
         end
         OP_ROTATE_LEFT_CARRY: begin
            result    = {operand[6:0], carry_in};
            carry_out = operand[7];
         end
         OP_ROTATE_RIGHT_CARRY: begin
            result    = {carry_in, operand[7:1]};
            carry_out = operand[0];
         end
         OP_ARITH_SHIFT_RIGHT: begin
            result    = {operand[7], operand[7:1]};
            carry_out = operand[0];
         end
         default: begin
            result    = operand;
            carry_out = carry_in;
         end
      endcase
   end

   // Flags derived from the result; V also uses the carry out.
   assign zero     = (result == 8'h00);
   assign negative = result[7];
   assign overflow = negative ^ carry_out;

endmodule : bfmu_shifter

// ---- logic/bfmu_unit.sv ----
`timescale 1ns/1ps

// Overview of operation
// - I/O bit set writes one to the addressed bit only, two cycles.
// - I/O bit clear writes zero to the addressed bit only, two cycles.
// - Rotate left through carry; carry into bit 0, bit 7 to carry.
// - Rotate right through carry; carry into bit 7, bit 0 to carry.
// - Arithmetic shift right keeps sign, updates Z C N V, one cycle.
// - Nibble swap exchanges halves, no flag change, one cycle.
// - Flag force one or zero on the selected status bit, one cycle.
// - Bit store copies selected register bit into transfer flag.
// - Bit load copies transfer flag into selected register bit.
// - Overflow flag raise and drop touch only that flag.
// - Signed flag raise and drop touch only that flag.
// - Half carry raise and drop touch only that flag.
// - Sleep takes one cycle and changes no flag.
// - Watchdog restart takes one cycle, no flags, pulses restart.
module bfmu_unit (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       op_valid,
   input  wire logic [4:0] op_code,
   input  wire logic [7:0] reg_operand,
   input  wire logic [2:0] bit_sel,
   input  wire logic [5:0] io_addr,
   input  wire logic [7:0] io_rdata,
   output logic            op_ready,
   output logic            op_done,
   output logic      [7:0] result_data,
   output logic            result_we,
   output logic      [5:0] io_waddr,
   output logic      [7:0] io_wdata,
   output logic            io_we,
   output logic      [7:0] status_register,
   output logic            sleep_req,
   output logic            watchdog_restart
);
   import bfmu_pkg::*;

   bfmu_state_t state_q;
   bfmu_state_t state_d;
   logic [7:0]  sr_q;
   logic [7:0]  sr_d;
   logic [7:0]  res_q;
   logic [7:0]  res_d;
   logic        res_we_q;
   logic        res_we_d;
   logic [5:0]  io_addr_q;
   logic [2:0]  io_bit_q;
   logic        io_set_q;
   logic [7:0]  io_wdata_q;
   logic        io_we_q;
   logic        done_q;
   logic        done_d;
   logic        sleep_q;
   logic        wdr_q;
   logic        take;
   logic [7:0]  sh_result;
   logic        sh_c;
   logic        sh_z;
   logic        sh_n;
   logic        sh_v;
   logic        is_shift;

   // The unit accepts a new operation only when no I/O update is pending.
   assign op_ready = (state_q == BFMU_IDLE);
   assign take     = op_valid && op_ready;

   bfmu_shifter u_shifter (
      .op        (op_code),
      .operand   (reg_operand),
      .carry_in  (sr_q[SR_C]),
      .result    (sh_result),
      .carry_out (sh_c),
      .zero      (sh_z),
      .negative  (sh_n),
      .overflow  (sh_v)
   );

   assign is_shift = (op_code == OP_LOGICAL_LEFT_SHIFT) ||
                     (op_code == OP_LOGICAL_RIGHT_SHIFT) ||
                     (op_code == OP_ROTATE_LEFT_CARRY) ||
                     (op_code == OP_ROTATE_RIGHT_CARRY) ||
                     (op_code == OP_ARITH_SHIFT_RIGHT);

   // Next status, register result and sequencing for each operation.
   always_comb begin
      sr_d     = sr_q;
      res_d    = res_q;
      res_we_d = 1'b0;
      done_d   = 1'b0;
      state_d  = state_q;
      case (state_q)
         BFMU_IDLE: begin
            if (take) begin
               if (is_shift) begin
                  res_d         = sh_result;
                  res_we_d      = 1'b1;
                  sr_d[SR_C]    = sh_c;
                  sr_d[SR_Z]    = sh_z;
                  sr_d[SR_N]    = sh_n;
                  sr_d[SR_V]    = sh_v;
                  done_d        = 1'b1;
               end else begin
                  case (op_code)
                     OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                        // Read-modify-write needs a second cycle.
                        state_d = BFMU_IO_RMW;
                     end
                     OP_NIBBLE_SWAP: begin
                        res_d    = {reg_operand[3:0],
                                    reg_operand[7:4]};
                        res_we_d = 1'b1;
                        done_d   = 1'b1;
                     end
                     OP_STATUS_BIT_FORCE_ONE: begin
                        // Covers V, S, H, C, N, Z, I and T raises.
                        sr_d[bit_sel] = 1'b1;
                        done_d        = 1'b1;
                     end
                     OP_STATUS_BIT_FORCE_ZERO: begin
                        sr_d[bit_sel] = 1'b0;
                        done_d        = 1'b1;
                     end
                     OP_REG_BIT_TO_TRANSFER: begin
                        sr_d[SR_T] = reg_operand[bit_sel];
                        done_d     = 1'b1;
                     end
                     OP_TRANSFER_TO_REG_BIT: begin
                        res_d          = reg_operand;
                        res_d[bit_sel] = sr_q[SR_T];
                        res_we_d       = 1'b1;
                        done_d         = 1'b1;
                     end
                     default: begin
                        // No-op, sleep and watchdog restart leave flags.
                        done_d = 1'b1;
                     end
                  endcase
               end
            end
         end
         BFMU_IO_RMW: begin
            done_d  = 1'b1;
            state_d = BFMU_IDLE;
         end
         default: begin
            state_d = BFMU_IDLE;
         end
      endcase
   end

   // Sequencer state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= BFMU_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Status register and result register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sr_q     <= SR_RESET;
         res_q    <= RES_RESET;
         res_we_q <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         sr_q     <= sr_d;
         res_q    <= res_d;
         res_we_q <= res_we_d;
         done_q   <= done_d;
      end
   end

   // Capture I/O target on acceptance; the read data is sampled next cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         io_addr_q <= 6'h00;
         io_bit_q  <= 3'h0;
         io_set_q  <= 1'b0;
      end else if (take && ((op_code == OP_IO_BIT_SET) ||
                            (op_code == OP_IO_BIT_CLEAR))) begin
         io_addr_q <= io_addr;
         io_bit_q  <= bit_sel;
         io_set_q  <= (op_code == OP_IO_BIT_SET);
      end
   end

   // Second cycle: merge the single bit into the read value, flags untouched.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         io_wdata_q <= 8'h00;
         io_we_q    <= 1'b0;
      end else if (state_q == BFMU_IO_RMW) begin
         io_wdata_q           <= io_rdata;
         io_wdata_q[io_bit_q] <= io_set_q;
         io_we_q              <= 1'b1;
      end else begin
         io_we_q <= 1'b0;
      end
   end

   // Control pulses for sleep and watchdog logic outside this unit.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleep_q <= 1'b0;
         wdr_q   <= 1'b0;
      end else begin
         sleep_q <= take && (op_code == OP_SLEEP);
         wdr_q   <= take && (op_code == OP_WATCHDOG_RESTART);
      end
   end

   assign status_register  = sr_q;
   assign result_data      = res_q;
   assign result_we        = res_we_q;
   assign io_waddr         = io_addr_q;
   assign io_wdata         = io_wdata_q;
   assign io_we            = io_we_q;
   assign op_done          = done_q;
   assign sleep_req        = sleep_q;
   assign watchdog_restart = wdr_q;

endmodule : bfmu_unit

// ---- verif/bfmu_unit_monitor.sv ----
`timescale 1ns/1ps

// Port-level relations of the unit; one clock domain, so shared defaults.
module bfmu_unit_monitor
   import bfmu_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       op_valid,
   input wire logic [4:0] op_code,
   input wire logic [7:0] reg_operand,
   input wire logic [2:0] bit_sel,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_rdata,
   input wire logic       op_ready,
   input wire logic       op_done,
   input wire logic [7:0] result_data,
   input wire logic       result_we,
   input wire logic [5:0] io_waddr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_we,
   input wire logic [7:0] status_register,
   input wire logic       sleep_req,
   input wire logic       watchdog_restart
);
   logic       acc;
   logic [7:0] sr;
   logic [7:0] ro;

   // Short names keep each property on a few lines.
   assign acc = op_valid & op_ready;
   assign sr  = status_register;
   assign ro  = reg_operand;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   io_set_a: assert property (
      acc && op_code == OP_IO_BIT_SET |=>
      !op_ready ##1 io_we && op_done && io_waddr == $past(io_addr, 2) &&
      io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_sel, 2))))
      else $error("io bit set wrong");
   io_clear_a: assert property (
      acc && op_code == OP_IO_BIT_CLEAR |=>
      !op_ready ##1 io_we && op_done && sr == $past(sr, 2) &&
      io_wdata == ($past(io_rdata) & ~(8'h01 << $past(bit_sel, 2))))
      else $error("io bit clear wrong");
   rotate_left_a: assert property (
      acc && op_code == OP_ROTATE_LEFT_CARRY |=>
      result_we && result_data == {$past(ro[6:0]), $past(sr[SR_C])} &&
      sr[SR_C] == $past(ro[7])) else $error("rotate left wrong");
   rotate_right_a: assert property (
      acc && op_code == OP_ROTATE_RIGHT_CARRY |=>
      result_we && result_data == {$past(sr[SR_C]), $past(ro[7:1])} &&
      sr[SR_C] == $past(ro[0])) else $error("rotate right wrong");
   arith_shift_a: assert property (
      acc && op_code == OP_ARITH_SHIFT_RIGHT |=>
      result_data == {$past(ro[7]), $past(ro[7:1])} &&
      sr[SR_C] == $past(ro[0])) else $error("arith shift wrong");
   shift_flags_a: assert property (
      acc && op_code inside {[5'h03:5'h07]} |=>
      sr[SR_Z] == (result_data == 8'h00) && sr[SR_N] == result_data[7] &&
      sr[SR_V] == (result_data[7] ^ sr[SR_C]))
      else $error("shift flags wrong");
   nibble_swap_a: assert property (
      acc && op_code == OP_NIBBLE_SWAP |=>
      result_data == {$past(ro[3:0]), $past(ro[7:4])} && $stable(sr))
      else $error("swap wrong");
   flag_force_a: assert property (
      acc && op_code == OP_STATUS_BIT_FORCE_ONE |=>
      op_done && sr == ($past(sr) | (8'h01 << $past(bit_sel))))
      else $error("flag force wrong");
   flag_clear_a: assert property (
      acc && op_code == OP_STATUS_BIT_FORCE_ZERO |=>
      op_done && sr == ($past(sr) & ~(8'h01 << $past(bit_sel))))
      else $error("flag clear wrong");
   bit_store_a: assert property (
      acc && op_code == OP_REG_BIT_TO_TRANSFER |=>
      sr == {$past(sr[7]), $past(ro[bit_sel]), $past(sr[5:0])})
      else $error("bit store wrong");
   bit_load_a: assert property (
      acc && op_code == OP_TRANSFER_TO_REG_BIT |=>
      result_we && result_data[$past(bit_sel)] == $past(sr[SR_T]) &&
      $stable(sr)) else $error("bit load wrong");
   control_op_a: assert property (
      acc && op_code == OP_SLEEP |=>
      sleep_req && !watchdog_restart && op_done && $stable(sr))
      else $error("sleep wrong");
   watchdog_op_a: assert property (
      acc && op_code == OP_WATCHDOG_RESTART |=>
      watchdog_restart && !sleep_req && op_done && $stable(sr))
      else $error("watchdog restart wrong");

   // The main traffic kinds must each be seen at least once.
   cover property (acc && op_code == OP_IO_BIT_SET);
   cover property (acc && op_code == OP_ROTATE_RIGHT_CARRY);
   cover property (acc && op_code == OP_WATCHDOG_RESTART);
endmodule : bfmu_unit_monitor

// ---- verif/bfmu_io_space.sv ----
`timescale 1ns/1ps

// I/O space behind the unit; a read follows the address taken at accept.
module bfmu_io_space (
   input wire logic       clk,
   input wire logic       take,
   input wire logic [5:0] io_addr,
   input wire logic [5:0] io_waddr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_we,
   output logic     [7:0] io_rdata
);
   logic [7:0] mem_q [64];
   logic [5:0] addr_q = 6'h00;

   // Each cell holds its address over a one, so reads are predictable.
   always @(posedge clk) begin
      if (take) addr_q <= io_addr;
      if (io_we) mem_q[io_waddr] <= io_wdata;
   end
   initial for (int i = 0; i < 64; i++) mem_q[i] = {i[5:0], 2'b01};
   assign io_rdata = mem_q[addr_q];
endmodule : bfmu_io_space

// ---- verif/bfmu_unit_tb.sv ----
`timescale 1ns/1ps

// Offers operations one at a time and compares with a local model.
module bfmu_unit_tb;
   import bfmu_pkg::*;
   logic       clk = 0, rst = 1, op_valid = 0, op_ready, op_done;
   logic       result_we, io_we, sleep_req, watchdog_restart;
   logic [4:0] op_code = 5'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [5:0] io_addr = 6'h00, io_waddr;
   logic [7:0] reg_operand = 8'h00, io_rdata, result_data, io_wdata;
   logic [7:0] status_register, sr_e;
   logic [8:0] sx;
   logic [7:0] vals [3] = '{8'h81, 8'h00, 8'h40};
   int         num_errors = 0, checks_done = 0;

   always #2.5 clk = ~clk;

   bfmu_unit bfmu_unit_inst (.clk(clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .reg_operand(reg_operand), .bit_sel(bit_sel),
      .io_addr(io_addr), .io_rdata(io_rdata), .op_ready(op_ready),
      .op_done(op_done), .result_data(result_data), .result_we(result_we),
      .io_waddr(io_waddr), .io_wdata(io_wdata), .io_we(io_we),
      .status_register(status_register), .sleep_req(sleep_req),
      .watchdog_restart(watchdog_restart));
   bfmu_io_space bfmu_io_space_inst (.clk(clk), .take(op_valid & op_ready),
      .io_addr(io_addr), .io_waddr(io_waddr), .io_wdata(io_wdata),
      .io_we(io_we), .io_rdata(io_rdata));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // Offers one operation, returns in the cycle where it has completed.
   task automatic run(input logic [4:0] c, input logic [7:0] d,
                      input logic [2:0] b, input logic [5:0] a);
      int n = 0;
      logic io_op;
      @(posedge clk);
      {op_valid, op_code, reg_operand, bit_sel, io_addr} <= {1'b1, c, d, b, a};
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      while (op_done !== 1'b1) begin
         if (++n > 4) begin
            num_errors++;
            final_report();
         end
         @(posedge clk);
         #1;
      end
      // Cycles from the accepting edge to op_done must match the op class.
      io_op = (c == OP_IO_BIT_SET) || (c == OP_IO_BIT_CLEAR);
      check(8'(n + 1), io_op ? 8'(IO_BIT_CYCLES) : 8'(ONE_CYCLE));
   endtask : run

   // Forces one status bit; the other seven must not move.
   task automatic flag(input logic v, input logic [2:0] s);
      run(v ? OP_STATUS_BIT_FORCE_ONE : OP_STATUS_BIT_FORCE_ZERO,
          8'h00, s, 6'h00);
      sr_e[s] = v;
      check(status_register, sr_e);
   endtask : flag

   // Reference shifter: carry out on top, result below.
   function automatic logic [8:0] shf(input logic [4:0] o,
                                      input logic [7:0] a, input logic c);
      case (o)
         OP_LOGICAL_LEFT_SHIFT:  return {a, 1'b0};
         OP_LOGICAL_RIGHT_SHIFT: return {a[0], 1'b0, a[7:1]};
         OP_ROTATE_LEFT_CARRY:   return {a, c};
         OP_ROTATE_RIGHT_CARRY:  return {a[0], c, a[7:1]};
         default:                return {a[0], a[7], a[7:1]};
      endcase
   endfunction : shf

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 check(status_register, SR_RESET);
      sr_e = SR_RESET;
      for (int s = 0; s < 8; s++)
         flag(1'b1, s[2:0]);
      for (int s = 7; s >= 0; s--)
         flag(1'b0, s[2:0]);
      // Every shift kind with both carry values and edge operands.
      for (int c = 0; c < 2; c++) for (int o = 3; o < 8; o++)
         for (int v = 0; v < 3; v++) begin
            flag(c[0], 3'(SR_C));
            sx = shf(o[4:0], vals[v], c[0]);
            run(o[4:0], vals[v], 3'h0, 6'h00);
            sr_e[SR_C] = sx[8];
            sr_e[SR_Z] = sx[7:0] == 8'h00;
            sr_e[SR_N] = sx[7];
            sr_e[SR_V] = sx[7] ^ sx[8];
            check(result_data, sx[7:0]);
            check(status_register, sr_e);
         end
      run(OP_NIBBLE_SWAP, 8'h3C, 3'h0, 6'h00);
      check(result_data, 8'hC3);
      check({7'h00, result_we}, 8'h01);
      run(OP_REG_BIT_TO_TRANSFER, 8'h80, 3'h7, 6'h00);
      sr_e[SR_T] = 1'b1;
      check(status_register, sr_e);
      run(OP_TRANSFER_TO_REG_BIT, 8'h00, 3'h0, 6'h00);
      check(result_data, 8'h01);
      check(status_register, sr_e);
      // I/O bit ops at both ends of the address range.
      run(OP_IO_BIT_SET, 8'h00, 3'h1, 6'h3F);
      check(io_wdata, 8'hFF);
      check({2'b00, io_waddr}, 8'h3F);
      run(OP_IO_BIT_CLEAR, 8'hFF, 3'h0, 6'h00);
      check(io_wdata, 8'h00);
      check(status_register, sr_e);
      run(OP_SLEEP, 8'h00, 3'h0, 6'h00);
      check({6'h00, sleep_req, watchdog_restart}, 8'h02);
      run(OP_WATCHDOG_RESTART, 8'h00, 3'h0, 6'h00);
      check({6'h00, sleep_req, watchdog_restart}, 8'h01);
      check(status_register, sr_e);
      // Mid-run reset: flags return to rest and the next operation works.
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1 check(status_register, SR_RESET);
      run(OP_ROTATE_LEFT_CARRY, 8'hC1, 3'h0, 6'h00);
      check(result_data, 8'h82);
      check(status_register, 8'h05);
      final_report();
   end
endmodule : bfmu_unit_tb

bind bfmu_unit bfmu_unit_monitor bfmu_unit_monitor_inst (.clk(clk),
   .rst(rst), .op_valid(op_valid), .op_code(op_code),
   .reg_operand(reg_operand), .bit_sel(bit_sel), .io_addr(io_addr),
   .io_rdata(io_rdata), .op_ready(op_ready), .op_done(op_done),
   .result_data(result_data), .result_we(result_we), .io_waddr(io_waddr),
   .io_wdata(io_wdata), .io_we(io_we), .status_register(status_register),
   .sleep_req(sleep_req), .watchdog_restart(watchdog_restart));
